// ---- hw/thcm_top.sv ----
// two-hand control monitor: evaluation, 500 ms window, release, fault, diagnostics
//
// Behaviour
// - evaluation selects single or dual channel; dual is in force after reset.
// - single channel uses inputs one and two, one make contact per button.
// - inputs three and four are only evaluated in dual-channel mode.
// - enable input gates the block when external enable is chosen; default not required.
// - release asserted only when every condition for normal operation holds.
// - fault asserted while an error is present, visible to any logic.
// - diagnostics word reports the current internal state.
// - relay supports up to seven single or three dual instances.
// - release lasts only while the station stays actuated.
// - release output can drive one or several safety outputs directly.
// - release only if the full actuation completes within 500 ms.
// - late actuation flags an error, cleared when buttons return to rest or the block is disabled.
// - any change on a monitored input drops an asserted release.
// - diagnostics codes mark rest, released, too late and operated at startup.
`timescale 1ns/1ps

module thcm_top
   import thcm_pkg::*;
#(
   parameter int unsigned WIN_CYC = THCM_WIN_CYC
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic        button_in_one,
   input  wire logic        button_in_two,
   input  wire logic        button_in_three,
   input  wire logic        button_in_four,
   input  wire logic        block_enable_in,
   input  wire logic        cfg_load_in,
   input  wire logic        cfg_dual_in,
   input  wire logic        cfg_ext_enable_in,
   output logic             release_out,
   output logic             fault_out,
   output logic [15:0]      diag_word_out
);

   localparam logic [THCM_CNT_W-1:0] WIN_LAST = THCM_CNT_W'(WIN_CYC - 1);

   // pattern of a correctly actuated station
   function automatic logic fn_actuated(input thcm_btn_s b, input logic dual);
      if (dual) begin
         fn_actuated = b.one & ~b.two & b.three & ~b.four;
      end else begin
         fn_actuated = b.one & b.two;
      end
   endfunction : fn_actuated

   // pattern of a station at rest
   function automatic logic fn_at_rest(input thcm_btn_s b, input logic dual);
      if (dual) begin
         fn_at_rest = ~b.one & b.two & ~b.three & b.four;
      end else begin
         fn_at_rest = ~b.one & ~b.two;
      end
   endfunction : fn_at_rest

   function automatic logic [15:0] fn_diag(input thcm_state_e s);
      unique case (s)
         THCM_ST_OFF:       fn_diag = THCM_DG_OFF;
         THCM_ST_START:     fn_diag = THCM_DG_REST;
         THCM_ST_REST:      fn_diag = THCM_DG_REST;
         THCM_ST_ARM:       fn_diag = THCM_DG_ARM;
         THCM_ST_ON:        fn_diag = THCM_DG_ON;
         THCM_ST_HOLD:      fn_diag = THCM_DG_HOLD;
         THCM_ST_ERR_LATE:  fn_diag = THCM_DG_LATE;
         THCM_ST_ERR_START: fn_diag = THCM_DG_START;
         default:           fn_diag = THCM_DG_OFF;
      endcase
   endfunction : fn_diag

   thcm_btn_s              btn;
   thcm_cfg_s              cfg_q;
   thcm_state_e            state_q;
   thcm_state_e            state_d;
   logic [THCM_CNT_W-1:0]  arm_cnt_q;
   logic                   active;
   logic                   act_now;
   logic                   rest_now;
   logic                   win_over;

   assign btn      = '{four: button_in_four, three: button_in_three,
                       two: button_in_two, one: button_in_one};
   assign active   = ~cfg_q.ext_enable | block_enable_in;
   assign act_now  = fn_actuated(btn, cfg_q.dual_channel_eval);
   assign rest_now = fn_at_rest(btn, cfg_q.dual_channel_eval);
   assign win_over = (arm_cnt_q == WIN_LAST);

   // configuration, defaults to dual channel without external enable
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cfg_q <= '{dual_channel_eval: THCM_RST_DUAL, ext_enable: THCM_RST_EXT_EN};
      end else if (cfg_load_in) begin
         cfg_q <= '{dual_channel_eval: cfg_dual_in, ext_enable: cfg_ext_enable_in};
      end
   end

   always_comb begin
      state_d = state_q;
      if (!active) begin
         state_d = THCM_ST_OFF;
      end else begin
         unique case (state_q)
            THCM_ST_OFF:   state_d = THCM_ST_START;
            THCM_ST_START: state_d = rest_now ? THCM_ST_REST : THCM_ST_ERR_START;
            THCM_ST_REST: begin
               if (!rest_now) begin
                  state_d = act_now ? THCM_ST_ON : THCM_ST_ARM;
               end
            end
            THCM_ST_ARM: begin
               if (act_now) begin
                  state_d = THCM_ST_ON;
               end else if (rest_now) begin
                  state_d = THCM_ST_REST;
               end else if (win_over) begin
                  state_d = THCM_ST_ERR_LATE;
               end
            end
            THCM_ST_ON: begin
               if (!act_now) begin
                  state_d = rest_now ? THCM_ST_REST : THCM_ST_HOLD;
               end
            end
            THCM_ST_HOLD,
            THCM_ST_ERR_LATE,
            THCM_ST_ERR_START: begin
               if (rest_now) begin
                  state_d = THCM_ST_REST;
               end
            end
            default: state_d = THCM_ST_OFF;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         state_q <= THCM_ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // synchronism window counter
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         arm_cnt_q <= '0;
      end else if (state_q == THCM_ST_ARM && state_d == THCM_ST_ARM && !win_over) begin
         arm_cnt_q <= arm_cnt_q + THCM_CNT_W'(1);
      end else if (state_q != THCM_ST_ARM) begin
         arm_cnt_q <= '0;
      end
   end

   // outputs registered alongside the state
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         release_out   <= 1'b0;
         fault_out     <= 1'b0;
         diag_word_out <= THCM_DG_OFF;
      end else begin
         release_out   <= (state_d == THCM_ST_ON);
         fault_out     <= (state_d == THCM_ST_ERR_LATE) ||
                          (state_d == THCM_ST_ERR_START);
         diag_word_out <= fn_diag(state_d);
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   rel_needs_act_a:
      assert property (release_out |-> $past(act_now) && $past(active))
      else $error("release without actuated station");

   rel_drop_a:
      assert property (release_out && !act_now |=> !release_out)
      else $error("release kept after input change");

   late_fault_a:
      assert property (state_q == THCM_ST_ARM && win_over && active && !act_now && !rest_now
                       |=> fault_out && diag_word_out == THCM_DG_LATE)
      else $error("late actuation not flagged");

   fault_hold_a:
      assert property (fault_out && active && !rest_now |=> fault_out)
      else $error("fault cleared away from rest");

   disabled_off_a:
      assert property (cfg_q.ext_enable && !block_enable_in
                       |=> !release_out && diag_word_out == THCM_DG_OFF)
      else $error("release while block disabled");

   single_ignore_a:
      assert property (state_q == THCM_ST_REST && active && !cfg_q.dual_channel_eval
                       && !button_in_one && !button_in_two |=> state_q == THCM_ST_REST)
      else $error("inputs three or four used in single channel");

   diag_release_a:
      assert property (release_out == (diag_word_out == THCM_DG_ON))
      else $error("diagnostics disagree with release");

   start_fault_a:
      assert property (state_q == THCM_ST_START && active && !rest_now
                       |=> fault_out && diag_word_out == THCM_DG_START)
      else $error("operated inputs at startup not flagged");

   win_bound_a:
      assert property (state_q == THCM_ST_ARM && win_over |=> state_q != THCM_ST_ARM)
      else $error("waiting state outlasts the window");

   win_count_a:
      assert property (state_q == THCM_ST_ARM && $past(state_q) == THCM_ST_ARM
                       && !$past(win_over)
                       |-> arm_cnt_q == $past(arm_cnt_q) + THCM_CNT_W'(1))
      else $error("window counter skipped a cycle");

   cfg_default_a:
      assert property ($rose(rst_b_in) |-> cfg_q.dual_channel_eval && !cfg_q.ext_enable)
      else $error("configuration default wrong");

   release_cov: cover property ($rose(release_out));
   late_cov:    cover property ($rose(fault_out) && diag_word_out == THCM_DG_LATE);
   start_cov:   cover property (diag_word_out == THCM_DG_START);
   single_cov:  cover property (release_out && !cfg_q.dual_channel_eval);

endmodule : thcm_top

// ---- hw/thcm_pkg.sv ----
// constants and types shared by the two-hand control monitor
package thcm_pkg;

   // timing
   localparam int unsigned THCM_CLK_HZ      = 20_000_000;
   localparam int unsigned THCM_WIN_MS      = 500;
   localparam int unsigned THCM_WIN_CYC     = THCM_WIN_MS * (THCM_CLK_HZ / 1000);
   localparam int unsigned THCM_CNT_W       = 24;

   // instance limits of the relay
   localparam int unsigned THCM_MAX_SINGLE  = 7;
   localparam int unsigned THCM_MAX_DUAL    = 3;

   // diagnostics codes
   localparam logic [15:0] THCM_DG_OFF      = 16'h0000;
   localparam logic [15:0] THCM_DG_REST     = 16'h2016;
   localparam logic [15:0] THCM_DG_ARM      = 16'h2017;
   localparam logic [15:0] THCM_DG_HOLD     = 16'h2018;
   localparam logic [15:0] THCM_DG_ON       = 16'h800B;
   localparam logic [15:0] THCM_DG_LATE     = 16'hF006;
   localparam logic [15:0] THCM_DG_START    = 16'hF018;

   // configuration after reset
   localparam logic        THCM_RST_DUAL    = 1'b1;
   localparam logic        THCM_RST_EXT_EN  = 1'b0;

   typedef enum logic [7:0] {
      THCM_ST_OFF       = 8'h01,
      THCM_ST_START     = 8'h02,
      THCM_ST_REST      = 8'h04,
      THCM_ST_ARM       = 8'h08,
      THCM_ST_ON        = 8'h10,
      THCM_ST_HOLD      = 8'h20,
      THCM_ST_ERR_LATE  = 8'h40,
      THCM_ST_ERR_START = 8'h80
   } thcm_state_e;

   typedef struct packed {
      logic four;
      logic three;
      logic two;
      logic one;
   } thcm_btn_s;

   typedef struct packed {
      logic dual_channel_eval;
      logic ext_enable;
   } thcm_cfg_s;

endpackage : thcm_pkg

// ---- sim/thcm_station.sv ----
// two-hand pushbutton station model driving the four contact lines
`timescale 1ns/1ps

module thcm_station (
   input  wire logic hand_one_in,
   input  wire logic hand_two_in,
   input  wire logic dual_in,
   input  wire logic junk_in,
   output logic      button_one_out,
   output logic      button_two_out,
   output logic      button_three_out,
   output logic      button_four_out
);
   assign button_one_out   = hand_one_in;
   assign button_two_out   = dual_in ? ~hand_one_in : hand_two_in;
   // unused lines in single mode carry a changing pattern
   assign button_three_out = dual_in ? hand_two_in : junk_in;
   assign button_four_out  = dual_in ? ~hand_two_in : ~junk_in;
endmodule : thcm_station

// ---- sim/tb.sv ----
// self-checking bench for the two-hand control monitor
`timescale 1ns/1ps

module tb;
   import thcm_pkg::*;
   localparam int unsigned WIN = 20;
   logic clk_sys_in, rst_b_in, h1, h2, dual_m, junk, en, ld, cd, ce;
   logic b1, b2, b3, b4, rel, flt;
   logic [15:0] diag;
   int err_total, total_checks;

   thcm_station thcm_station_inst (.hand_one_in(h1), .hand_two_in(h2), .dual_in(dual_m),
      .junk_in(junk), .button_one_out(b1), .button_two_out(b2), .button_three_out(b3),
      .button_four_out(b4));
   thcm_top #(.WIN_CYC(WIN)) thcm_top_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .button_in_one(b1), .button_in_two(b2), .button_in_three(b3), .button_in_four(b4),
      .block_enable_in(en), .cfg_load_in(ld), .cfg_dual_in(cd), .cfg_ext_enable_in(ce),
      .release_out(rel), .fault_out(flt), .diag_word_out(diag));

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   task cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : cyc

   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task outs(input logic r, input logic f, input logic [15:0] d);
      check({15'h0000, rel}, {15'h0000, r});
      check({15'h0000, flt}, {15'h0000, f});
      check(diag, d);
   endtask : outs

   task load(input logic dual, input logic ext);
      cd = dual;
      ce = ext;
      ld = 1'b1;
      cyc(1);
      ld = 1'b0;
   endtask : load

   task t_reset;
      outs(1'b0, 1'b0, THCM_DG_OFF);
      cyc(4);
      outs(1'b0, 1'b0, THCM_DG_REST);
      $display("test reset done");
   endtask : t_reset

   task t_dual_ok;
      h1 = 1'b1;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_ARM);
      cyc(WIN - 6);
      h2 = 1'b1;
      cyc(2);
      outs(1'b1, 1'b0, THCM_DG_ON);
      h2 = 1'b0;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_HOLD);
      h1 = 1'b0;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_REST);
      $display("test dual release done");
   endtask : t_dual_ok

   task t_late;
      h1 = 1'b1;
      cyc(WIN + 4);
      outs(1'b0, 1'b1, THCM_DG_LATE);
      h2 = 1'b1;
      cyc(2);
      outs(1'b0, 1'b1, THCM_DG_LATE);
      h1 = 1'b0;
      h2 = 1'b0;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_REST);
      $display("test late press done");
   endtask : t_late

   task t_single;
      dual_m = 1'b0;
      load(1'b0, 1'b0);
      cyc(4);
      outs(1'b0, 1'b0, THCM_DG_REST);
      junk = 1'b1;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_REST);
      h1 = 1'b1;
      h2 = 1'b1;
      cyc(2);
      outs(1'b1, 1'b0, THCM_DG_ON);
      junk = 1'b0;
      cyc(2);
      outs(1'b1, 1'b0, THCM_DG_ON);
      h2 = 1'b0;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_HOLD);
      h1 = 1'b0;
      dual_m = 1'b1;
      load(1'b1, 1'b0);
      cyc(4);
      outs(1'b0, 1'b0, THCM_DG_REST);
      $display("test single channel done");
   endtask : t_single

   task t_enable;
      en = 1'b0;
      load(1'b1, 1'b1);
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_OFF);
      h1 = 1'b1;
      h2 = 1'b1;
      cyc(3);
      outs(1'b0, 1'b0, THCM_DG_OFF);
      en = 1'b1;
      cyc(4);
      outs(1'b0, 1'b1, THCM_DG_START);
      h1 = 1'b0;
      h2 = 1'b0;
      cyc(2);
      outs(1'b0, 1'b0, THCM_DG_REST);
      load(1'b1, 1'b0);
      en = 1'b0;
      cyc(3);
      outs(1'b0, 1'b0, THCM_DG_REST);
      $display("test enable done");
   endtask : t_enable

   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      #(3000 * 50);
      err_total++;
      tally_and_finish;
   end

   initial begin
      err_total = 0;
      total_checks = 0;
      {rst_b_in, h1, h2, junk, en, ld, cd, ce} = 8'h00;
      dual_m = 1'b1;
      cyc(2);
      rst_b_in = 1'b1;
      t_reset;
      t_dual_ok;
      t_late;
      t_single;
      t_enable;
      tally_and_finish;
   end
endmodule : tb
